// ---- hdl/usb_gated_watchdog.sv ----
/*
 Gated watchdog with its register file on AXI4-Lite.
 Assumes SYS_CLK at 20 MHz, synchronous RSTN as power-up reset, SOF and
 USB reset as one-cycle pulses from same-clock USB logic, and an
 active-low external interrupt pin from outside the clock domain.
 A time-out needs 32 ticks without access, so short runs never reach it.
 The core reset output is a level pulse; the core is expected to sample it.
*/
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "dog_map.svh"
module usb_gated_watchdog (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // AXI4-Lite write address
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // USB events
    input wire logic USB_SOF,
    input wire logic USB_RESET,
    // External interrupt pin, active low
    input wire logic EXT_IRQ_LINE_ONE_N,
    // Outputs
    output logic CORE_RESET,
    output logic IRQ
);
    import dog_pkg::*;

    // Bus channel state
    logic aw_ff;
    logic [4:0] awaddr_ff;
    logic w_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic do_wr;
    logic do_rd;
    logic wr_wdcs;
    logic rd_wdcs;
    logic lane0;


    // Watchdog state; the count is cleared by a WDCS read or a WDCS write with byte lane 0 strobed
    logic enable_ff;
    logic cause_ff;
    logic usbrst_en_ff;
    logic sof_seen_ff;
    logic core_idle_bit_ff;
    dog_count_t count_ff;
    logic [7:0] rst_cnt_ff;
    logic tick;
    logic irq_seen;
    logic running;
    logic refresh;
    logic timeout;
    event_vec_t stat_ff;
    event_vec_t ien_ff;
    event_vec_t evt;


    // Millisecond time base, free-running from power-up
    // Its phase is not tied to firmware, so the first period may be short
    ms_tick u_tick (
        .sys_clk(SYS_CLK),
        .rstn(RSTN),
        .tick(tick)
    );


    // Interrupt pin qualifier; a short glitch never wakes the core
    irq_qual u_irq (
        .sys_clk(SYS_CLK),
        .rstn(RSTN),
        .irq_n_pin(EXT_IRQ_LINE_ONE_N),
        .irq_seen(irq_seen)
    );

    // Bus handshakes; address and data captured in either order
    assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
    assign S_AXI_WREADY = !w_ff && !bvalid_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = 2'h0;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = 2'h0;
    assign do_wr = aw_ff && w_ff && !bvalid_ff;
    assign do_rd = S_AXI_ARVALID && !rvalid_ff;
    assign lane0 = wstrb_ff[0];

    // Write channel capture and response
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read decode; unmapped words read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case ({S_AXI_ARADDR[4:2], 2'b00})
            5'(`OFF_WDCS): begin
                nxt_rdata[`BIT_ENABLE] = enable_ff;
                nxt_rdata[`BIT_CAUSE] = cause_ff;
            end
            5'(`OFF_POWER): nxt_rdata[`BIT_IDLE] = core_idle_bit_ff;
            5'(`OFF_OPTS): nxt_rdata[`BIT_USBRST_EN] = usbrst_en_ff;
            5'(`OFF_ISTAT): nxt_rdata[2:0] = stat_ff;
            `OFF_IEN: nxt_rdata[2:0] = ien_ff;
            `OFF_COUNT: nxt_rdata[4:0] = count_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read answer one cycle after address
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else if (do_rd) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign wr_wdcs = do_wr && lane0 && ({awaddr_ff[4:2], 2'b00} == 5'(`OFF_WDCS));
    assign rd_wdcs = do_rd && ({S_AXI_ARADDR[4:2], 2'b00} == 5'(`OFF_WDCS));

    // only a written one refreshes and blocks a time-out; a WDCS write with zero still clears the count
    assign refresh = wr_wdcs && wdata_ff[`BIT_REFRESH];
    // run only when enabled, SOF seen and not idle
    assign running = enable_ff && sof_seen_ff && !core_idle_bit_ff;
    // A refresh in the tick cycle wins, so a late write still saves the core
    // time-out needs enable and SOF qualification
    assign timeout = running && tick && (count_ff == `DOG_TIMEOUT_MS) && !refresh;

    // enable set by firmware, cleared by power-up or allowed USB reset
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            enable_ff <= 1'b0;
        end else if (USB_RESET && usbrst_en_ff) begin
            enable_ff <= 1'b0;
        end else if (wr_wdcs && wdata_ff[`BIT_ENABLE]) begin
            enable_ff <= 1'b1;
        end
    end

    // cause flag; time-out set wins over a clear
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            cause_ff <= 1'b0;
        end else if (timeout) begin
            cause_ff <= 1'b1;
        end else if (USB_RESET && usbrst_en_ff) begin
            cause_ff <= 1'b0;
        end else if (wr_wdcs && wdata_ff[`BIT_CAUSE]) begin
            cause_ff <= 1'b0;
        end
    end

    // USB-reset-clears-enable option
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            usbrst_en_ff <= 1'b1;
        end else if (do_wr && lane0 && ({awaddr_ff[4:2], 2'b00} == 5'(`OFF_OPTS))) begin
            usbrst_en_ff <= wdata_ff[`BIT_USBRST_EN];
        end
    end

    // start-of-frame qualification, dropped by USB reset
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            sof_seen_ff <= 1'b0;
        end else if (USB_RESET) begin
            sof_seen_ff <= 1'b0;
        end else if (USB_SOF) begin
            sof_seen_ff <= 1'b1;
        end
    end

    // idle set by firmware, cleared by a qualified interrupt
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            core_idle_bit_ff <= 1'b0;
        end else if (irq_seen) begin
            core_idle_bit_ff <= 1'b0;
        end else if (do_wr && lane0 && ({awaddr_ff[4:2], 2'b00} == 5'(`OFF_POWER))
                     && wdata_ff[`BIT_IDLE]) begin
            core_idle_bit_ff <= 1'b1;
        end
    end

    // five-bit millisecond count, cleared on refresh or access
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            count_ff <= 5'h00;
        end else if (refresh || rd_wdcs || wr_wdcs || !enable_ff || timeout) begin
            count_ff <= 5'h00;
        end else if (running && tick) begin
            count_ff <= count_ff + 5'h01;
        end
    end


    // Sixteen cycles keep the core in reset long enough to settle
    // core reset pulse stretched after time-out
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rst_cnt_ff <= 8'h00;
        end else if (timeout) begin
            rst_cnt_ff <= `CORE_RST_CYC;
        end else if (rst_cnt_ff != 8'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
        end
    end
    assign CORE_RESET = (rst_cnt_ff != 8'h00);


    // Bit 1 fires on the first frame marker after power-up or after each USB reset
    // Events: time-out, SOF qualification, qualified interrupt
    assign evt = {irq_seen, USB_SOF && !sof_seen_ff, timeout};


    // Clear register is write-one-to-clear; zeros leave bits alone
    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            stat_ff <= 3'h0;
        end else if (do_wr && lane0 && (awaddr_ff == `OFF_ICLR)) begin
            stat_ff <= (stat_ff & ~wdata_ff[2:0]) | evt;
        end else begin
            stat_ff <= stat_ff | evt;
        end
    end

    // Interrupt enable register
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ien_ff <= 3'h0;
        end else if (do_wr && lane0 && (awaddr_ff == `OFF_IEN)) begin
            ien_ff <= wdata_ff[2:0];
        end
    end

    // Level output, high while an enabled status bit is set
    assign IRQ = |(stat_ff & ien_ff);
endmodule

// ---- shared/dog_map.svh ----
/*
 Register offsets, field positions, reset values and timing counts
 of the gated watchdog. Assumes a 20 MHz system clock and a 32-bit
 AXI4-Lite register bus.
*/
`ifndef DOG_MAP_SVH
`define DOG_MAP_SVH

`define CLK_HZ 20000000
`define TICK_US 1000
`define TICK_CYC ((`CLK_HZ / 1000000) * `TICK_US)
`define IRQ_HOLD_US 400
`define IRQ_HOLD_CYC ((`CLK_HZ / 1000000) * `IRQ_HOLD_US)
`define DOG_TIMEOUT_MS 5'h1F
`define CORE_RST_CYC 8'h10

`define OFF_WDCS 4'h0
`define OFF_POWER 4'h4
`define OFF_OPTS 4'h8
`define OFF_ISTAT 4'hC
`define OFF_ICLR 5'h10
`define OFF_IEN 5'h14
`define OFF_COUNT 5'h18

`define BIT_REFRESH 0
`define BIT_CAUSE 6
`define BIT_ENABLE 7
`define BIT_IDLE 0
`define BIT_USBRST_EN 0

`define RST_WDCS 8'h00
`define RST_OPTS 8'h01

`endif

// ---- shared/dog_pkg.sv ----
/*
 Types shared by the watchdog files.
 Assumes the map header for numbers.
*/
package dog_pkg;
    typedef enum logic [1:0] {
        IRQ_SOFF,
        IRQ_SON
    } irq_sync_t;
    typedef logic [4:0] dog_count_t;
    typedef logic [2:0] event_vec_t;
endpackage

// ---- hdl/ms_tick.sv ----
/*
 Millisecond tick generator.
 Assumes the 20 MHz system clock and synchronous low reset.
*/
`timescale 1ns/10ps
`include "dog_map.svh"
module ms_tick (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Tick
    output logic tick
);
    logic [14:0] div_ff;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            div_ff <= 15'h0000;
            tick <= 1'b0;
        end else if (div_ff == 15'(`TICK_CYC - 1)) begin
            div_ff <= 15'h0000;
            tick <= 1'b1;
        end else begin
            div_ff <= div_ff + 15'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// ---- hdl/irq_qual.sv ----
/*
 Qualifies the external interrupt line: synchronised, then it must
 stay asserted (low) for the full hold time before a pulse is issued.
 Assumes an asynchronous active-low pin.
*/
`timescale 1ns/10ps
`include "dog_map.svh"
module irq_qual (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Pin and pulse
    input wire logic irq_n_pin,
    output logic irq_seen
);
    import dog_pkg::*;
    logic s1_ff;
    logic s2_ff;
    logic [13:0] hold_ff;
    irq_sync_t st_ff;

    // Two-stage synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end else begin
            s1_ff <= irq_n_pin;
            s2_ff <= s1_ff;
        end
    end

    // hold-time qualification, one pulse per assertion
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hold_ff <= 14'h0000;
            st_ff <= IRQ_SOFF;
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= 1'b0;
            unique case (st_ff)
                IRQ_SOFF: begin
                    if (s2_ff) begin
                        hold_ff <= 14'h0000;
                    end else if (hold_ff == 14'(`IRQ_HOLD_CYC - 1)) begin
                        irq_seen <= 1'b1;
                        st_ff <= IRQ_SON;
                    end else begin
                        hold_ff <= hold_ff + 14'h0001;
                    end
                end
                IRQ_SON: begin
                    hold_ff <= 14'h0000;
                    if (s2_ff) begin
                        st_ff <= IRQ_SOFF;
                    end
                end
            endcase
        end
    end
endmodule

// ---- bench/usb_gated_watchdog_chk.sv ----
/*
 Port checker for the gated watchdog.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module usb_gated_watchdog_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Bus handshakes
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Watchdog output
    input wire logic CORE_RESET
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    logic [7:0] len_ff;
    // Length of the running core reset pulse
    always_ff @(posedge SYS_CLK) begin
        len_ff <= (CORE_RESET && RSTN) ? len_ff + 8'h01 : 8'h00;
    end
    sequence both_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence pulse_on;
        CORE_RESET [*8];
    endsequence
    bresp_stand_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    rdata_stand_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("read data dropped early");
    write_block_a: assert property (S_AXI_BVALID |-> !(S_AXI_AWREADY || S_AXI_WREADY))
        else $error("write taken while response pending");
    read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while data pending");
    write_answer_a: assert property (both_taken |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    core_hold_a: assert property ($rose(CORE_RESET) |-> pulse_on)
        else $error("core reset pulse too short");
    core_len_a: assert property ($fell(CORE_RESET) |-> len_ff == 8'h10)
        else $error("core reset pulse not 16 cycles");
endmodule

bind usb_gated_watchdog usb_gated_watchdog_chk usb_gated_watchdog_chk_i (.*);

// ---- bench/usb_side_model.sv ----
/*
 Far side: USB frame marker and external interrupt pin.
 Assumes the bench requests each event with a one-cycle strobe.
*/
`timescale 1ns/10ps
module usb_side_model (
    // Clock and requests
    input wire logic clk,
    input wire logic sof_go,
    input wire logic irq_go,
    input wire logic [15:0] hold,
    // Pins towards the block
    output logic sof = 1'b0,
    output logic irq_n = 1'b1
);
    int left = 0;
    // One-cycle frame marker
    always @(posedge clk) sof <= sof_go;
    // pin held low
    // Released pin rests high, as a pulled-up line would
    always @(posedge clk) begin
        if (irq_go) left <= hold;
        else if (left > 0) left <= left - 1;
        irq_n <= !(irq_go || left > 1);
    end
endmodule

// ---- bench/usb_gated_watchdog_tb.sv ----
/*
 Self-checking bench: bus tasks, integer register model, timeouts.
 Assumes the side model drives frame marker and interrupt pin.
*/
`timescale 1ns/10ps
`include "dog_map.svh"
module usb_gated_watchdog_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic usb_rst = 0, sof_go = 0, irq_go = 0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] hold = 16'h0;
    logic awready, wready, bvalid, arready, rvalid, sof, irq_n, irq, irq_q = 1;
    logic core_rst;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    int m_en = 0, m_cause = 0, m_idle = 0, m_cnt = 0, m_sof = 0, m_opt = 1;
    int m_stat = 0, m_ien = 0;
    bit go = 0;

    always #25 clk = ~clk;

    usb_gated_watchdog usb_gated_watchdog_i (
        .SYS_CLK(clk), .RSTN(rstn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .USB_SOF(sof),
        .USB_RESET(usb_rst), .EXT_IRQ_LINE_ONE_N(irq_n), .CORE_RESET(core_rst), .IRQ(irq));

    usb_side_model usb_side_model_i (.clk(clk), .sof_go(sof_go), .irq_go(irq_go),
        .hold(hold), .sof(sof), .irq_n(irq_n));

    // Model tick, frame and idle exit; runs only when enabled, framed, awake
    always @(posedge clk) begin
        if (go) cyc++;
        if (go && cyc % 20000 == 0 && m_en && m_sof && !m_idle) m_cnt++;
        if (sof) m_sof = 1;
        if (sof) m_stat |= 2;
        if (irq_n && !irq_q && m_idle) m_stat |= 4;
        if (irq_n && !irq_q) m_idle = 0;
        irq_q = irq_n;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] mexp(input logic [4:0] a);
        case (a)
            `OFF_WDCS: return 32'(m_en * 128 + m_cause * 64);
            `OFF_POWER: return 32'(m_idle);
            `OFF_OPTS: return 32'(m_opt);
            `OFF_ISTAT: return 32'(m_stat);
            `OFF_IEN: return 32'(m_ien);
            `OFF_COUNT: return 32'(m_cnt);
            default: return 32'h0;
        endcase
    endfunction

    // Write: both channels offered together, released as each is taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!tb && n < 50);
        bready <= 1'b0;
        if (a == `OFF_WDCS) m_cnt = 0;
        case (a)
            `OFF_WDCS: m_en |= d[7];
            `OFF_POWER: m_idle |= d[0];
            `OFF_OPTS: m_opt = d[0];
            `OFF_ICLR: m_stat &= ~d[2:0];
            `OFF_IEN: m_ien = d[2:0];
            default: ;
        endcase
        if (a == `OFF_WDCS && d[6]) m_cause = 0;
    endtask

    // Read: data captured at the edge where the answer is sampled
    task automatic rd(input logic [4:0] a);
        logic ta, tr;
        logic [31:0] d;
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (!tr && n < 50);
        rready <= 1'b0;
        chk("read data", d, mexp(a));
        if (a == `OFF_WDCS) m_cnt = 0;
    endtask

    task automatic upto(input int c);
        while (cyc < c) @(posedge clk);
    endtask

    task automatic irq_chk;
        repeat (3) @(negedge clk);
        chk("irq", 32'(irq), 32'(|(m_stat & m_ien)));
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, beyond the planned 101000 cycles
    initial begin
        repeat (120000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        void'($urandom(17));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        go <= 1'b1;
        rd(`OFF_WDCS);
        rd(`OFF_OPTS);
        rd(`OFF_ISTAT);
        rd(`OFF_COUNT);
        wr(5'h1C, $urandom);
        rd(5'h1C);
        wr(`OFF_WDCS, 32'h81);
        rd(`OFF_WDCS);
        wr(`OFF_WDCS, $urandom & 32'h3E);
        rd(`OFF_WDCS);
        upto(30000);
        rd(`OFF_COUNT);
        sof_go <= 1'b1;
        @(posedge clk);
        sof_go <= 1'b0;
        upto(50000);
        rd(`OFF_COUNT);
        rd(`OFF_ISTAT);
        irq_chk();
        wr(`OFF_IEN, 32'h2);
        irq_chk();
        wr(`OFF_ICLR, 32'h2);
        irq_chk();
        upto(70000);
        rd(`OFF_COUNT);
        rd(`OFF_WDCS);
        rd(`OFF_COUNT);
        wr(`OFF_POWER, 32'h1);
        wr(`OFF_IEN, 32'h4);
        upto(85000);
        rd(`OFF_COUNT);
        hold <= 16'(8500 + $urandom % 500);
        irq_go <= 1'b1;
        @(posedge clk);
        irq_go <= 1'b0;
        upto(96000);
        rd(`OFF_POWER);
        irq_chk();
        upto(101000);
        rd(`OFF_COUNT);
        usb_rst <= 1'b1;
        @(posedge clk);
        usb_rst <= 1'b0;
        m_en = 0;
        m_sof = 0;
        rd(`OFF_WDCS);
        chk("core reset", 32'(core_rst), 32'h0);
        print_verdict();
    end
endmodule
